//--- verilog/cbs_bus_seq.sv
// Micro-state bus sequencer: execute patterns, bus hold, interrupt entry, wait and halt
`include "cbs_regs.svh"

module cbs_bus_seq (
	// Clock and reset
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_arst_n,
	// Requests from the shared bus
	input  wire logic                 i_bus_hold_req_n,
	input  wire logic                 i_nmi_req_n,
	input  wire logic                 i_maskable_irq_req_n,
	input  wire logic                 i_data_ready_in,
	input  wire logic                 i_halt_toggle_n,
	// Decoded instruction, taken during the instruction's data-in state; store data is taken again during the write state
	input  wire cbs_pkg::cbs_iclass_e i_instr_class,
	input  wire logic                 i_shift_double,
	input  wire logic [15:0]          i_operand_addr,
	input  wire logic [15:0]          i_store_data,
	// Interrupt enable flop control from instruction execution
	input  wire logic                 i_irq_enable_set,
	input  wire logic                 i_irq_enable_clr,
	// Multiplexed data bus, split into three signals
	input  wire logic [15:0]          i_bus_data,
	output logic      [15:0]          o_bus_data,
	output logic                      o_bus_data_oe,
	// Bus control
	output logic                      o_bus_ctl_1,
	output logic                      o_bus_ctl_2,
	output logic                      o_bus_ctl_dir,
	output logic                      o_bus_hold_grant_n,
	// Status
	output logic                      o_halted,
	output logic                      o_irq_enable
);

	logic [1:0]                 slot_ff;
	logic                       slot_one;
	logic                       slot_four;
	cbs_pkg::cbs_state_e        state_ff;
	cbs_pkg::cbs_state_e        nxt_state;
	cbs_pkg::cbs_state_e        after_instr;
	logic [2:0]                 step_ff;
	logic [2:0]                 nxt_step;
	cbs_pkg::cbs_iclass_e       iclass_ff;
	cbs_pkg::cbs_iclass_e       exec_class;
	logic                       dbl_ff;
	cbs_pkg::cbs_bus_ctl_s      bus_ctl_ff;
	cbs_pkg::cbs_bus_ctl_s      nxt_bus_ctl;
	logic [15:0]                bus_data_ff;
	logic [15:0]                nxt_bus_data;
	logic                       bus_oe_ff;
	logic                       nxt_bus_oe;
	logic                       grant_n_ff;
	logic [15:0]                pc_ff;
	logic [15:0]                sp_ff;
	logic                       hold_meta_ff;
	logic                       hold_ff;
	logic                       nmi_meta_ff;
	logic                       nmi_ff;
	logic                       nmi_prev_ff;
	logic                       nmi_pend_ff;
	logic                       mirq_meta_ff;
	logic                       mirq_ff;
	logic                       irq_en_ff;
	logic                       irq_go;
	logic                       rdy_meta_ff;
	logic                       rdy_sync_ff;
	logic                       addr_prev_ff;
	logic                       wait_ff;
	logic                       advance;
	logic                       halt_meta_ff;
	logic                       halt_sync_ff;
	logic                       halt_prev_ff;
	logic                       halted_ff;

	// Execute pattern per class and step
	function automatic logic [2:0] exec_code(input cbs_pkg::cbs_iclass_e ic,
			input logic [2:0] st);
		logic [2:0] code;
		code = `CBS_BC_IDLE;
		unique case (ic)
			cbs_pkg::ic_input: begin
				code = (st == 3'h0) ? `CBS_BC_DATA_IN : `CBS_BC_IDLE;
			end
			cbs_pkg::ic_move_out: begin
				if (st == 3'h0) begin
					code = `CBS_BC_WRITE;
				end else if (st == 3'h1) begin
					code = `CBS_BC_STROBE;
				end
			end
			cbs_pkg::ic_double: begin
				if (st == 3'h0) begin
					code = `CBS_BC_ADDR_LATCH;
				end else if (st == 3'h2) begin
					code = `CBS_BC_DATA_IN;
				end
			end
			cbs_pkg::ic_reg_reg,
			cbs_pkg::ic_shift: begin
				code = `CBS_BC_IDLE;
			end
			default: begin
				code = `CBS_BC_IDLE;
			end
		endcase
		return code;
	endfunction

	// Last execute step; every pattern spans two to four micro states
	function automatic logic [2:0] exec_last(input cbs_pkg::cbs_iclass_e ic,
			input logic dbl);
		logic [2:0] last;
		last = `CBS_LAST_REG_REG;
		unique case (ic)
			cbs_pkg::ic_input:    last = `CBS_LAST_INPUT;
			cbs_pkg::ic_move_out: last = `CBS_LAST_MOVE_OUT;
			cbs_pkg::ic_double:   last = `CBS_LAST_DOUBLE;
			cbs_pkg::ic_reg_reg:  last = `CBS_LAST_REG_REG;
			cbs_pkg::ic_shift:    last = dbl ? `CBS_LAST_SHIFT_2 : `CBS_LAST_SHIFT_1;
			default:              last = `CBS_LAST_REG_REG;
		endcase
		return last;
	endfunction

	// Four slots per micro state, one clock each
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			slot_ff <= `CBS_SLOT_ONE;
		end else begin
			slot_ff <= slot_ff + 2'h1;
		end
	end
	assign slot_one  = (slot_ff == `CBS_SLOT_ONE);
	assign slot_four = (slot_ff == `CBS_SLOT_FOUR);

	// Asynchronous requests: first flop feeds only the slot-one sampling flop
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hold_meta_ff <= 1'b1;
			hold_ff      <= 1'b0;
			nmi_meta_ff  <= 1'b1;
			nmi_ff       <= 1'b1;
			nmi_prev_ff  <= 1'b1;
			mirq_meta_ff <= 1'b1;
			mirq_ff      <= 1'b1;
		end else begin
			hold_meta_ff <= i_bus_hold_req_n;
			nmi_meta_ff  <= i_nmi_req_n;
			mirq_meta_ff <= i_maskable_irq_req_n;
			// Edge seen for one clock only, so a clear at entry is not undone
			nmi_prev_ff  <= nmi_ff;
			if (slot_one) begin
				hold_ff     <= !hold_meta_ff;
				nmi_ff      <= nmi_meta_ff;
				mirq_ff     <= mirq_meta_ff;
			end
		end
	end

	// Non-maskable request is latched on its falling edge so one pulse gives one entry
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			nmi_pend_ff <= 1'b0;
		end else if (nmi_prev_ff && !nmi_ff) begin
			nmi_pend_ff <= 1'b1;
		end else if (slot_four && nxt_state == cbs_pkg::st_int_ack) begin
			nmi_pend_ff <= 1'b0;
		end
	end

	// Enable flop; a set in the accept cycle wins over the automatic clear
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_en_ff <= 1'b0;
		end else if (i_irq_enable_set) begin
			irq_en_ff <= 1'b1;
		end else if (i_irq_enable_clr || (slot_four && nxt_state == cbs_pkg::st_int_ack)) begin
			irq_en_ff <= 1'b0;
		end
	end

	assign irq_go = nmi_pend_ff || (!mirq_ff && irq_en_ff);

	// Ready: low caught in slot one after an address latch, rise caught in slot four
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdy_meta_ff <= 1'b1;
			rdy_sync_ff <= 1'b1;
			wait_ff     <= 1'b0;
		end else begin
			rdy_meta_ff <= i_data_ready_in;
			rdy_sync_ff <= rdy_meta_ff;
			if (slot_one && addr_prev_ff) begin
				wait_ff <= !i_data_ready_in;
			end else if (slot_four && rdy_sync_ff) begin
				wait_ff <= 1'b0;
			end
		end
	end
	assign advance = !wait_ff || rdy_sync_ff;

	// Halt toggles on falling edges of the synchronised pin only
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			halt_meta_ff <= 1'b1;
			halt_sync_ff <= 1'b1;
			halt_prev_ff <= 1'b1;
			halted_ff    <= 1'b0;
		end else begin
			halt_meta_ff <= i_halt_toggle_n;
			halt_sync_ff <= halt_meta_ff;
			halt_prev_ff <= halt_sync_ff;
			if (halt_prev_ff && !halt_sync_ff) begin
				halted_ff <= !halted_ff;
			end
		end
	end

	// End-of-instruction decision: hold first, then interrupt, then halt, else fetch
	always_comb begin
		if (hold_ff) begin
			after_instr = cbs_pkg::st_hold;
		end else if (irq_go) begin
			after_instr = cbs_pkg::st_int_ack;
		end else if (halted_ff) begin
			after_instr = cbs_pkg::st_halt;
		end else begin
			after_instr = cbs_pkg::st_fetch_addr;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_step  = step_ff;
		unique case (state_ff)
			cbs_pkg::st_fetch_addr: nxt_state = cbs_pkg::st_fetch_gap;
			cbs_pkg::st_fetch_gap: begin
				if (advance) begin
					nxt_state = cbs_pkg::st_fetch_data;
				end
			end
			cbs_pkg::st_fetch_data: begin
				nxt_state = cbs_pkg::st_exec;
				nxt_step  = 3'h0;
			end
			cbs_pkg::st_exec: begin
				if (advance) begin
					if (step_ff == exec_last(iclass_ff, dbl_ff)) begin
						nxt_state = after_instr;
					end else begin
						nxt_step = step_ff + `CBS_STEP_ONE;
					end
				end
			end
			cbs_pkg::st_hold,
			cbs_pkg::st_halt:       nxt_state = after_instr;
			cbs_pkg::st_int_ack:    nxt_state = cbs_pkg::st_int_write;
			cbs_pkg::st_int_write:  nxt_state = cbs_pkg::st_int_strobe;
			cbs_pkg::st_int_strobe: nxt_state = cbs_pkg::st_int_vector;
			cbs_pkg::st_int_vector: nxt_state = cbs_pkg::st_fetch_addr;
		endcase
	end

	// Class flop loads on the edge that starts execution; first step reads the port
	assign exec_class = (state_ff == cbs_pkg::st_fetch_data) ? i_instr_class : iclass_ff;

	// Bus code and drive for the coming micro state
	always_comb begin
		nxt_bus_ctl  = cbs_pkg::cbs_bus_ctl_s'(`CBS_BC_IDLE);
		nxt_bus_data = bus_data_ff;
		nxt_bus_oe   = 1'b0;
		unique case (nxt_state)
			cbs_pkg::st_fetch_addr: begin
				nxt_bus_ctl  = cbs_pkg::cbs_bus_ctl_s'(`CBS_BC_ADDR_LATCH);
				nxt_bus_data = (state_ff == cbs_pkg::st_int_vector) ? i_bus_data : pc_ff;
				nxt_bus_oe   = 1'b1;
			end
			cbs_pkg::st_fetch_data: nxt_bus_ctl = cbs_pkg::cbs_bus_ctl_s'(`CBS_BC_DATA_IN);
			cbs_pkg::st_exec: begin
				nxt_bus_ctl = cbs_pkg::cbs_bus_ctl_s'(exec_code(exec_class, nxt_step));
				if (nxt_bus_ctl == cbs_pkg::cbs_bus_ctl_s'(`CBS_BC_ADDR_LATCH)) begin
					nxt_bus_data = i_operand_addr;
					nxt_bus_oe   = 1'b1;
				end else if (exec_class == cbs_pkg::ic_move_out && nxt_step != 3'h2) begin
					nxt_bus_data = i_store_data;
					nxt_bus_oe   = 1'b1;
				end
			end
			cbs_pkg::st_int_ack: begin
				nxt_bus_ctl  = cbs_pkg::cbs_bus_ctl_s'(`CBS_BC_IRQ_ACCEPT);
				nxt_bus_data = sp_ff;
				nxt_bus_oe   = 1'b1;
			end
			cbs_pkg::st_int_write,
			cbs_pkg::st_int_strobe: begin
				nxt_bus_ctl  = (nxt_state == cbs_pkg::st_int_write) ?
					cbs_pkg::cbs_bus_ctl_s'(`CBS_BC_WRITE) :
					cbs_pkg::cbs_bus_ctl_s'(`CBS_BC_STROBE);
				nxt_bus_data = pc_ff;
				nxt_bus_oe   = 1'b1;
			end
			cbs_pkg::st_int_vector: nxt_bus_ctl = cbs_pkg::cbs_bus_ctl_s'(`CBS_BC_VECTOR);
			// Gap, hold and halt keep the idle code and a released bus
			cbs_pkg::st_fetch_gap,
			cbs_pkg::st_hold,
			cbs_pkg::st_halt: nxt_bus_oe = 1'b0;
		endcase
	end

	// Sequencer and bus outputs change only at the slot-four boundary
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_ff     <= cbs_pkg::st_hold;
			step_ff      <= 3'h0;
			bus_ctl_ff   <= cbs_pkg::cbs_bus_ctl_s'(`CBS_BC_IDLE);
			bus_data_ff  <= `CBS_PC_RESET;
			bus_oe_ff    <= 1'b0;
			grant_n_ff   <= 1'b1;
			addr_prev_ff <= 1'b0;
		end else if (slot_four) begin
			state_ff     <= nxt_state;
			step_ff      <= nxt_step;
			bus_ctl_ff   <= nxt_bus_ctl;
			bus_data_ff  <= nxt_bus_data;
			bus_oe_ff    <= nxt_bus_oe;
			grant_n_ff   <= (nxt_state != cbs_pkg::st_hold);
			// Marks the state after a latch, whose first slot looks at ready
			addr_prev_ff <= (bus_ctl_ff == cbs_pkg::cbs_bus_ctl_s'(`CBS_BC_ADDR_LATCH)) ||
				(bus_ctl_ff == cbs_pkg::cbs_bus_ctl_s'(`CBS_BC_ADDR_DATA));
		end
	end

	// Program counter, stack pointer and latched instruction class
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pc_ff     <= `CBS_PC_RESET;
			sp_ff     <= `CBS_SP_RESET;
			iclass_ff <= cbs_pkg::ic_reg_reg;
			dbl_ff    <= 1'b0;
		end else if (slot_four) begin
			unique case (state_ff)
				cbs_pkg::st_fetch_addr: pc_ff <= pc_ff + `CBS_PTR_STEP;
				cbs_pkg::st_fetch_data: begin
					iclass_ff <= i_instr_class;
					dbl_ff    <= i_shift_double;
				end
				cbs_pkg::st_int_strobe: sp_ff <= sp_ff + `CBS_PTR_STEP;
				cbs_pkg::st_int_vector: pc_ff <= i_bus_data;
				default: begin
				end
			endcase
		end
	end

	assign o_bus_data         = bus_data_ff;
	assign o_bus_data_oe      = bus_oe_ff;
	assign o_bus_ctl_1        = bus_ctl_ff.bc1;
	assign o_bus_ctl_2        = bus_ctl_ff.bc2;
	assign o_bus_ctl_dir      = bus_ctl_ff.dir;
	assign o_bus_hold_grant_n = grant_n_ff;
	assign o_halted           = halted_ff;
	assign o_irq_enable       = irq_en_ff;

endmodule // cbs_bus_seq

//--- verilog/cbs_regs.svh
// Named constants of the bus sequencer: bus codes, slot indices, lengths, reset values
`ifndef CBS_REGS_SVH
`define CBS_REGS_SVH

// Bus function codes, packed as {bus_ctl_dir, bus_ctl_2, bus_ctl_1}
`define CBS_BC_IDLE        3'h0
`define CBS_BC_ADDR_DATA   3'h1
`define CBS_BC_VECTOR      3'h2
`define CBS_BC_DATA_IN     3'h3
`define CBS_BC_ADDR_LATCH  3'h4
`define CBS_BC_WRITE       3'h5
`define CBS_BC_STROBE      3'h6
`define CBS_BC_IRQ_ACCEPT  3'h7

// Time slots within one micro state
`define CBS_SLOT_ONE       2'h0
`define CBS_SLOT_FOUR      2'h3

// Last step index of each execute pattern (length minus one)
`define CBS_LAST_INPUT     3'h1
`define CBS_LAST_MOVE_OUT  3'h2
`define CBS_LAST_DOUBLE    3'h2
`define CBS_LAST_REG_REG   3'h1
`define CBS_LAST_SHIFT_1   3'h1
`define CBS_LAST_SHIFT_2   3'h3

// Reset values and pointer step
`define CBS_PC_RESET       16'h0000
`define CBS_SP_RESET       16'h0000
`define CBS_PTR_STEP       16'h0001
`define CBS_STEP_ONE       3'h1

`endif

//--- verilog/cbs_pkg.sv
// Types shared by the bus sequencer
package cbs_pkg;

	typedef struct packed {
		logic dir;
		logic bc2;
		logic bc1;
	} cbs_bus_ctl_s;

	typedef enum logic [2:0] {
		ic_input,
		ic_move_out,
		ic_double,
		ic_reg_reg,
		ic_shift
	} cbs_iclass_e;

	typedef enum logic [3:0] {
		st_fetch_addr,
		st_fetch_gap,
		st_fetch_data,
		st_exec,
		st_hold,
		st_halt,
		st_int_ack,
		st_int_write,
		st_int_strobe,
		st_int_vector
	} cbs_state_e;

endpackage

//--- tb/cbs_bus_seq_asserts.sv
// Concurrent checks on the bus sequencer ports
`include "cbs_regs.svh"
module cbs_bus_seq_asserts (
	// Clock and reset
	input wire logic        i_ref_clk,
	input wire logic        i_arst_n,
	// Watched signals
	input wire logic        i_bus_hold_req_n,
	input wire logic [15:0] i_bus_data,
	input wire logic [15:0] o_bus_data,
	input wire logic        o_bus_data_oe,
	input wire logic        o_bus_ctl_1,
	input wire logic        o_bus_ctl_2,
	input wire logic        o_bus_ctl_dir,
	input wire logic        o_bus_hold_grant_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] ctl;
	logic [6:0] hold_wait_ff;
	assign ctl = {o_bus_ctl_dir, o_bus_ctl_2, o_bus_ctl_1};
	// Bounded by the longest instruction plus two short waits, not by the rules
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			hold_wait_ff <= 7'h00;
		else if (i_bus_hold_req_n || !o_bus_hold_grant_n)
			hold_wait_ff <= 7'h00;
		else
			hold_wait_ff <= hold_wait_ff + 7'h01;
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	sequence new_code(logic [2:0] c);
		$changed(ctl) && ctl == c;
	endsequence
	AST_SLOT_STEADY: assert property ($changed(ctl) |=> $stable(ctl)[*3])
		else $error("bus code changed inside a micro state");
	AST_HOLD_IDLE: assert property (!o_bus_hold_grant_n |-> ctl == `CBS_BC_IDLE && !o_bus_data_oe)
		else $error("bus used while granted");
	AST_HOLD_KEEP: assert property ((!i_bus_hold_req_n)[*6] ##0 !o_bus_hold_grant_n
		|=> !o_bus_hold_grant_n)
		else $error("grant dropped while request held");
	AST_HOLD_BOUND: assert property (hold_wait_ff < 7'h50)
		else $error("hold request not granted in time");
	AST_WRITE_PAIR: assert property (new_code(`CBS_BC_WRITE) |-> o_bus_data_oe
		##4 (ctl == `CBS_BC_STROBE && o_bus_data == $past(o_bus_data, 4))
		##4 ctl inside {`CBS_BC_IDLE, `CBS_BC_VECTOR})
		else $error("write not followed by strobe of same data");
	AST_ACCEPT_FIRST: assert property (new_code(`CBS_BC_IRQ_ACCEPT) |-> o_bus_data_oe
		##4 ctl == `CBS_BC_WRITE)
		else $error("accept state not followed by write");
	AST_VECTOR_LOAD: assert property (new_code(`CBS_BC_VECTOR) |-> !o_bus_data_oe
		##4 (ctl == `CBS_BC_ADDR_LATCH && o_bus_data == $past(i_bus_data)))
		else $error("vector not fetched from");
	AST_LATCH_IDLE: assert property (new_code(`CBS_BC_ADDR_LATCH) |-> o_bus_data_oe
		##4 ctl == `CBS_BC_IDLE)
		else $error("address latch not followed by idle");
	AST_IN_RELEASED: assert property (ctl inside {`CBS_BC_IDLE, `CBS_BC_DATA_IN, `CBS_BC_VECTOR}
		|-> !o_bus_data_oe)
		else $error("bus driven during an input code");
	cover property (!o_bus_hold_grant_n);
	cover property (new_code(`CBS_BC_IRQ_ACCEPT));
	cover property (new_code(`CBS_BC_STROBE));
endmodule // cbs_bus_seq_asserts

bind cbs_bus_seq cbs_bus_seq_asserts i_cbs_bus_seq_asserts (.i_ref_clk(i_ref_clk),
	.i_arst_n(i_arst_n), .i_bus_hold_req_n(i_bus_hold_req_n), .i_bus_data(i_bus_data),
	.o_bus_data(o_bus_data), .o_bus_data_oe(o_bus_data_oe), .o_bus_ctl_1(o_bus_ctl_1),
	.o_bus_ctl_2(o_bus_ctl_2), .o_bus_ctl_dir(o_bus_ctl_dir),
	.o_bus_hold_grant_n(o_bus_hold_grant_n));

//--- tb/cbs_bus_partner.sv
// Behavioural memory and vector source on the far side of the bus
`include "cbs_regs.svh"
module cbs_bus_partner (
	// Clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_arst_n,
	// Bus as seen from memory
	input  wire logic [2:0]  i_ctl,
	input  wire logic [3:0]  i_waits,
	input  wire logic [15:0] i_vector,
	output logic             o_ready,
	output logic      [15:0] o_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0]  prev_ctl;
	logic [15:0] last;
	int          low_cnt;
	// No pull-up: a released bus shows the inverse of what was last driven
	always_comb begin
		if (i_ctl == `CBS_BC_DATA_IN)
			o_data = 16'h0200;
		else if (i_ctl == `CBS_BC_VECTOR)
			o_data = i_vector;
		else
			o_data = ~last;
	end
	always @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prev_ctl = `CBS_BC_IDLE;
			low_cnt = 0;
			o_ready = 1'b1;
			last = 16'h0000;
		end else begin
			// Wait asked 10 ns into slot one of the state after an address latch
			#10;
			if (i_ctl != prev_ctl && prev_ctl inside {`CBS_BC_ADDR_LATCH, `CBS_BC_ADDR_DATA})
				low_cnt = 4 * i_waits;
			o_ready = (low_cnt == 0);
			if (low_cnt > 0)
				low_cnt--;
			if (i_ctl inside {`CBS_BC_DATA_IN, `CBS_BC_VECTOR})
				last = o_data;
			prev_ctl = i_ctl;
		end
	end
endmodule // cbs_bus_partner

//--- tb/tb.sv
// Self-checking bench for the bus sequencer
`include "cbs_regs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [2:0]  code;
		logic [15:0] data;
	} cbs_ent_s;
	localparam logic [2:0] BL = `CBS_BC_ADDR_LATCH;
	localparam logic [2:0] ID = `CBS_BC_IDLE;
	localparam logic [2:0] DI = `CBS_BC_DATA_IN;
	localparam logic [2:0] WR = `CBS_BC_WRITE;
	localparam logic [2:0] ST = `CBS_BC_STROBE;
	localparam logic [2:0] IA = `CBS_BC_IRQ_ACCEPT;
	localparam logic [2:0] VF = `CBS_BC_VECTOR;
	logic                 clk = 1'b0;
	logic                 arst_n, hold_n, nmi_n, mirq_n, halt_n, shdbl, en_set, en_clr, ready;
	logic                 oe, bc1, bc2, bus_ctl_dir, grant_n, halted, irq_en;
	logic [15:0]          op_addr, st_data, bus_in, bus_out, vec;
	logic [3:0]           waits;
	logic [1:0]           ph;
	cbs_pkg::cbs_iclass_e iclass;
	cbs_ent_s             trace[$];
	int                   error_cnt = 0;
	int                   n_checks = 0;

	cbs_bus_seq i_cbs_bus_seq (.i_ref_clk(clk), .i_arst_n(arst_n), .i_bus_hold_req_n(hold_n),
		.i_nmi_req_n(nmi_n), .i_maskable_irq_req_n(mirq_n), .i_data_ready_in(ready),
		.i_halt_toggle_n(halt_n), .i_instr_class(iclass), .i_shift_double(shdbl),
		.i_operand_addr(op_addr), .i_store_data(st_data), .i_irq_enable_set(en_set),
		.i_irq_enable_clr(en_clr), .i_bus_data(bus_in), .o_bus_data(bus_out),
		.o_bus_data_oe(oe), .o_bus_ctl_1(bc1), .o_bus_ctl_2(bc2), .o_bus_ctl_dir(bus_ctl_dir),
		.o_bus_hold_grant_n(grant_n), .o_halted(halted), .o_irq_enable(irq_en));
	cbs_bus_partner i_cbs_bus_partner (.i_ref_clk(clk), .i_arst_n(arst_n),
		.i_ctl({bus_ctl_dir, bc2, bc1}), .i_waits(waits), .i_vector(vec), .o_ready(ready),
		.o_data(bus_in));

	always #50 clk = ~clk;
	// Slot phase kept by the bench; a new micro state starts when it wraps
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ph <= 2'h0;
		else
			ph <= ph + 2'h1;
	end
	always @(negedge clk) begin
		if (arst_n && ph == 2'h0)
			trace.push_back({bus_ctl_dir, bc2, bc1, bus_out});
	end

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	function automatic int find(input logic [2:0] p[$]);
		int k;
		for (int i = 0; i + p.size() <= trace.size(); i++) begin
			for (k = 0; k < p.size() && trace[i + k].code === p[k]; k++);
			if (k == p.size())
				return i;
		end
		return -1;
	endfunction
	task automatic run_class(input cbs_pkg::cbs_iclass_e c, input logic d,
		input logic [2:0] p[$], output int at);
		iclass = c;
		shdbl = d;
		cyc(40);
		trace.delete();
		cyc(64);
		at = find(p);
		chk("pattern", 16'h1, 16'(at >= 0));
	endtask

	task automatic t_hold_irq;
		int at;
		trace.delete();
		hold_n = 1'b0;
		nmi_n = 1'b0;
		cyc(8);
		nmi_n = 1'b1;
		for (int n = 0; n < 100 && grant_n !== 1'b0; n++)
			cyc(1);
		chk("grant", 16'h0, 16'(grant_n));
		cyc(30);
		chk("grant held", 16'h0, 16'(grant_n));
		chk("accept in hold", 16'h0, 16'(find('{IA}) >= 0));
		hold_n = 1'b1;
		cyc(12);
		chk("grant release", 16'h1, 16'(grant_n));
		cyc(40);
		at = find('{IA, WR, ST, VF, BL});
		chk("irq entry", 16'h1, 16'(at >= 0));
		chk("stack address", `CBS_SP_RESET, trace[at].data);
		chk("new pc", vec, trace[at + 4].data);
	endtask
	task automatic t_exec;
		int at;
		run_class(cbs_pkg::ic_input, 1'b0, '{BL, ID, DI, DI, ID, BL}, at);
		run_class(cbs_pkg::ic_move_out, 1'b0, '{BL, ID, DI, WR, ST, ID, BL}, at);
		chk("store data", st_data, trace[at + 3].data);
		run_class(cbs_pkg::ic_double, 1'b0, '{BL, ID, DI, BL, ID, DI, BL}, at);
		chk("operand address", op_addr, trace[at + 3].data);
		run_class(cbs_pkg::ic_reg_reg, 1'b0, '{BL, ID, DI, ID, ID, BL}, at);
		run_class(cbs_pkg::ic_shift, 1'b0, '{BL, ID, DI, ID, ID, BL}, at);
		run_class(cbs_pkg::ic_shift, 1'b1, '{BL, ID, DI, ID, ID, ID, ID, BL}, at);
	endtask
	task automatic t_wait;
		int at;
		int cnt;
		waits = 4'h2;
		run_class(cbs_pkg::ic_input, 1'b0, '{BL, ID}, at);
		for (cnt = 0; at + 1 + cnt < trace.size() && trace[at + 1 + cnt].code === ID; cnt++);
		chk("wait length", 16'h1, 16'(cnt >= 2 && cnt <= 5));
		chk("after wait", 16'(DI), 16'(trace[at + 1 + cnt].code));
		waits = 4'h0;
	endtask
	task automatic t_mask;
		int at;
		en_set = 1'b1;
		cyc(1);
		en_set = 1'b0;
		cyc(2);
		chk("enable set", 16'h1, 16'(irq_en));
		en_clr = 1'b1;
		cyc(1);
		en_clr = 1'b0;
		cyc(2);
		chk("enable clear", 16'h0, 16'(irq_en));
		mirq_n = 1'b0;
		trace.delete();
		cyc(100);
		chk("masked", 16'h0, 16'(find('{IA}) >= 0));
		en_set = 1'b1;
		cyc(1);
		en_set = 1'b0;
		cyc(60);
		mirq_n = 1'b1;
		at = find('{IA, WR, ST, VF});
		chk("maskable entry", 16'h1, 16'(at >= 0));
		chk("stack step", `CBS_SP_RESET + `CBS_PTR_STEP, trace[at].data);
		chk("enable after entry", 16'h0, 16'(irq_en));
	endtask
	task automatic t_halt;
		// Pulses 400 ns low and 2.4 us apart, inside the allowed width and rate
		halt_n = 1'b0;
		cyc(4);
		chk("halt on", 16'h1, 16'(halted));
		halt_n = 1'b1;
		cyc(20);
		chk("rise ignored", 16'h1, 16'(halted));
		halt_n = 1'b0;
		cyc(4);
		chk("halt off", 16'h0, 16'(halted));
		halt_n = 1'b1;
		cyc(20);
	endtask

	// About five times the expected run length
	initial begin
		#500000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		{hold_n, nmi_n, mirq_n, halt_n} = 4'hF;
		{shdbl, en_set, en_clr} = 3'h0;
		iclass = cbs_pkg::ic_reg_reg;
		op_addr = 16'hA5C3;
		st_data = 16'h3C5A;
		vec = 16'h4B20;
		waits = 4'h0;
		arst_n = 1'b0;
		repeat (10) @(negedge clk);
		arst_n = 1'b1;
		t_hold_irq();
		t_exec();
		t_wait();
		t_mask();
		t_halt();
		tally_and_finish();
	end
endmodule // tb
